/* rtl/dms_autosetup.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dms_params.svh"
module dms_autosetup import dms_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // start and sensor presence
  input  wire logic        start,
  input  wire logic        enc_index_present,
  input  wire logic        hall_present,
  // measurement engine
  output logic             meas_req,
  output dms_meas_t        meas_step,
  input  wire logic        meas_done,
  input  wire logic        meas_err,
  input  wire logic        meas_index,
  // parameter store
  output logic             store_req,
  output logic [7:0]       store_cat,
  input  wire logic        store_done,
  // result
  output logic             busy,
  output logic             done,
  output logic             index_found
);
  dms_as_state_t state_reg, state_next;
  dms_meas_t     step_next;

  // optional steps depend on the sensors fitted
  function automatic dms_meas_t next_step(input dms_meas_t s, input logic enc, input logic hall);
    dms_meas_t n;
    n = dms_meas_t'(s + 3'h1);
    if ((n == DMS_MEAS_ENC) && !enc)
      n = DMS_MEAS_HALL;                                          // [RQ19]
    if ((n == DMS_MEAS_HALL) && !hall)
      n = DMS_MEAS_END;                                           // [RQ19]
    return n;
  endfunction

  wire last_cat = (store_cat == `DMS_CAT_TUNE);
  assign step_next = next_step(meas_step, enc_index_present, hall_present);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DMS_AS_IDLE:  if (start) state_next = DMS_AS_MEAS;          // [RQ11]
      DMS_AS_MEAS:  state_next = DMS_AS_WAIT;
      DMS_AS_WAIT: begin
        if (meas_done)
          state_next = meas_err ? DMS_AS_IDLE :
                       (step_next == DMS_MEAS_END) ? DMS_AS_STORE : DMS_AS_MEAS;
      end
      DMS_AS_STORE: state_next = DMS_AS_SWAIT;
      DMS_AS_SWAIT: if (store_done) state_next = last_cat ? DMS_AS_IDLE : DMS_AS_STORE;
      default:      state_next = DMS_AS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= DMS_AS_IDLE;
      meas_step   <= DMS_MEAS_TYPE;
      meas_req    <= 1'b0;
      store_req   <= 1'b0;
      store_cat   <= `DMS_CAT_DRIVE;
      busy        <= 1'b0;
      done        <= 1'b0;
      index_found <= 1'b0;
    end else begin
      state_reg <= state_next;
      meas_req  <= (state_next == DMS_AS_MEAS);
      store_req <= (state_next == DMS_AS_STORE);
      busy      <= (state_next != DMS_AS_IDLE);
      if (state_reg == DMS_AS_IDLE && start) begin
        meas_step   <= DMS_MEAS_TYPE;                             // [RQ19]
        store_cat   <= `DMS_CAT_DRIVE;
        done        <= 1'b0;
        index_found <= 1'b0;
      end
      if (state_reg == DMS_AS_WAIT && meas_done && !meas_err) begin
        meas_step <= step_next;
        if (meas_step == DMS_MEAS_ALIGN)
          index_found <= meas_index;                              // [RQ13]
      end
      if (state_reg == DMS_AS_SWAIT && store_done)
        store_cat <= `DMS_CAT_TUNE;                               // [RQ15]
      // a failed measurement also ends the run, but skips the store
      if (state_next == DMS_AS_IDLE && state_reg != DMS_AS_IDLE)
        done <= 1'b1;                                             // [RQ12]
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_drive_stored;
    (state_reg == DMS_AS_SWAIT) && store_done && (store_cat == `DMS_CAT_DRIVE);
  endsequence
  sequence s_tune_req;
    store_req && (store_cat == `DMS_CAT_TUNE);
  endsequence

  a_start_measure: assert property ((state_reg == DMS_AS_IDLE) && start |-> // [RQ11]
    ##1 meas_req && (meas_step == DMS_MEAS_TYPE))
    else $error("auto setup did not start measuring");
  a_store_order: assert property (s_drive_stored |-> ##1 s_tune_req) // [RQ15]
    else $error("tuning category not stored after drive");
  a_hall_skip: assert property (meas_req && (meas_step == DMS_MEAS_HALL) // [RQ19]
    |-> hall_present)
    else $error("hall step without hall sensor");
  a_enc_skip: assert property (meas_req && (meas_step inside {DMS_MEAS_ENC, DMS_MEAS_ALIGN}) // [RQ19]
    |-> enc_index_present)
    else $error("encoder step without index encoder");
  a_done_end: assert property ($rose(done) |-> $past(busy) && !busy) // [RQ12]
    else $error("done raised while running");
endmodule
`default_nettype wire

/* rtl/dms_mode_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dms_params.svh"
module dms_mode_decode import dms_pkg::*; (
  // switches, bit 0 is switch 1
  input  wire logic [3:0]  sw,
  input  wire logic        sw_en,
  // decoded selection
  output dms_mode_t        mode,
  output logic             dir_ccw,
  output logic             joystick,
  output logic [10:0]      speed_max,
  output logic             closed_loop
);
  wire use_sw = sw_en;
  assign mode = !use_sw ? DMS_MODE_NONE :
                sw[0] ? DMS_MODE_ANALOG :                         // [RQ3]
                sw[1] ? DMS_MODE_TEST : DMS_MODE_CLKDIR;          // [RQ1] [RQ2]
  assign dir_ccw = use_sw & ~sw[0] & sw[1] & sw[2];               // [RQ2]
  assign joystick = use_sw & sw[0] & sw[1];                       // [RQ3]
  assign speed_max = !use_sw ? 11'h000 :
                     sw[0] ? (sw[2] ? `DMS_MAX_LO : `DMS_MAX_HI) : // [RQ4]
                     sw[1] ? `DMS_TEST_RPM : 11'h000;
  assign closed_loop = use_sw & sw[3];                            // [RQ5]
endmodule
`default_nettype wire

/* rtl/dms_params.svh */
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH
// register byte offsets
`define DMS_A_CTRL      8'h00
`define DMS_A_STATUS    8'h04
`define DMS_A_OPMODE    8'h08
`define DMS_A_CFG       8'h0c
`define DMS_A_PROG      8'h10
`define DMS_A_DRIVE     8'h14
// field positions and values
`define DMS_CW_START    4
`define DMS_SW_INDEX    10
`define DMS_SW_DONE     12
`define DMS_OPM_AUTOSET 8'hfe
`define DMS_CFG_SWEN    0
`define DMS_CFG_AUTORUN 1
`define DMS_CFG_RST     2'h1
// speeds in rpm
`define DMS_TEST_RPM    11'h01e
`define DMS_MAX_HI      11'h3e8
`define DMS_MAX_LO      11'h064
// storage categories
`define DMS_CAT_DRIVE   8'h05
`define DMS_CAT_TUNE    8'h06
// analog input: 12-bit converter over 10 V, dead band 20 mV
`define DMS_ADC_FS_MV   10000
`define DMS_ADC_SPAN    4096
`define DMS_DEAD_MV     20
`define DMS_DEAD_CNT    12'((`DMS_DEAD_MV * `DMS_ADC_SPAN) / `DMS_ADC_FS_MV)
`define DMS_ADC_MID     12'h800
`endif

/* rtl/dms_pkg.sv */
package dms_pkg;
  typedef enum logic [1:0] {
    DMS_MODE_NONE, DMS_MODE_CLKDIR, DMS_MODE_TEST, DMS_MODE_ANALOG
  } dms_mode_t;
  typedef enum logic [2:0] {
    DMS_MEAS_TYPE, DMS_MEAS_RES, DMS_MEAS_IND, DMS_MEAS_FLUX,
    DMS_MEAS_ENC, DMS_MEAS_ALIGN, DMS_MEAS_HALL, DMS_MEAS_END
  } dms_meas_t;
  typedef enum logic [2:0] {
    DMS_AS_IDLE, DMS_AS_MEAS, DMS_AS_WAIT, DMS_AS_STORE, DMS_AS_SWAIT
  } dms_as_state_t;
endpackage

/* rtl/dms_top.sv */
// Contract
// RQ1: switches 1 and 2 off select clock-direction, switch 3 ignored.
// RQ2: switch 1 off, 2 on: 30 rpm test run, switch 3 sets direction.
// RQ3: switch 1 on: analog speed; switch 2 picks direction input or joystick.
// RQ4: analog full scale is 1000 rpm, or 100 rpm with switch 3 on.
// RQ5: switch 4 off means open loop, on means closed loop.
// RQ6: switches and configuration are sampled only at restart.
// RQ7: switches are used by default, ignored when configuration disables them.
// RQ8: digital input 4 enables motion in every special drive mode.
// RQ9: clock-direction sets operating mode internally; outside drives enable, clock, direction.
// RQ10: host writes 0xfe to operating mode and reaches operation enabled.
// RQ11: controlword bit 4 set starts the auto setup measurements.
// RQ12: statusword bit 12 shows the auto setup has ended.
// RQ13: statusword bit 10 shows whether an encoder index was found.
// RQ14: host starts auto setup only while no user program runs.
// RQ15: successful auto setup stores values under categories 05 and 06.
// RQ16: user program starts at power-up only when configured to.
// RQ17: restart file write restarts the device; start-up then deletes it.
// RQ18: missing program file at start-up is created empty.
// RQ19: auto setup measures basics, encoder and hall steps only when fitted.
// RQ20: test run turns at 30 rpm while enable is set.
// RQ21: joystick centre is zero speed with 20 mV dead band.
// RQ22: drive mode and loop choice are latched at reset and held.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dms_params.svh"
module dms_top import dms_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // switches and drive inputs
  input  wire logic [3:0]  dip_sw,
  input  wire logic        din4_enable,
  input  wire logic [11:0] adc_value,
  input  wire logic        pwr_op_enabled,
  // storage events
  input  wire logic        restart_file_wr,
  input  wire logic        prog_file_present,
  output logic             restart_file_del,
  output logic             prog_file_create,
  output logic             prog_start,
  output logic             sys_restart,
  // selected drive configuration
  output dms_mode_t        drv_mode,
  output logic             drv_dir_ccw,
  output logic             drv_joystick,
  output logic [10:0]      drv_speed_max,
  output logic             drv_closed_loop,
  output logic             cd_opmode_set,
  output logic             motion_en,
  output logic [10:0]      test_speed_rpm,
  output logic             analog_hold,
  // auto setup engine
  input  wire logic        enc_index_present,
  input  wire logic        hall_present,
  output logic             meas_req,
  output dms_meas_t        meas_step,
  input  wire logic        meas_done,
  input  wire logic        meas_err,
  input  wire logic        meas_index,
  output logic             store_req,
  output logic [7:0]       store_cat,
  input  wire logic        store_done
);
  logic [15:0] ctrl_reg;
  logic        cw_start_prev_reg;
  logic [7:0]  opmode_reg;
  logic [1:0]  cfg_reg;
  logic        prog_run_reg;
  logic        startup_reg;
  logic        restart_pend_reg;
  logic        as_busy;
  logic        as_done;
  logic        as_index;
  dms_mode_t   dec_mode;
  logic        dec_dir_ccw;
  logic        dec_joystick;
  logic [10:0] dec_speed_max;
  logic        dec_closed_loop;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // apb: no wait state; pready, pslverr and prdata are loaded in the setup phase so every bus output stands in a flop
  wire setup_ph = psel & ~penable & ~pready;
  wire acc_ph   = psel & penable & pready;
  wire wr_acc   = acc_ph & pwrite & ~pslverr;
  wire mapped   = sel(paddr, `DMS_A_CTRL) | sel(paddr, `DMS_A_STATUS) |
                  sel(paddr, `DMS_A_OPMODE) | sel(paddr, `DMS_A_CFG) |
                  sel(paddr, `DMS_A_PROG) | sel(paddr, `DMS_A_DRIVE);
  wire wr_ctrl  = wr_acc & sel(paddr, `DMS_A_CTRL);
  wire wr_opm   = wr_acc & sel(paddr, `DMS_A_OPMODE);
  wire wr_cfg   = wr_acc & sel(paddr, `DMS_A_CFG);
  wire wr_prog  = wr_acc & sel(paddr, `DMS_A_PROG);

  wire [31:0] status_word = {19'h00000, as_done, 1'b0, as_index, 10'h000} &
                            ((32'h1 << `DMS_SW_DONE) | (32'h1 << `DMS_SW_INDEX));
  wire [31:0] drive_word  = {16'h0000, drv_speed_max, drv_closed_loop,
                             drv_joystick, drv_dir_ccw, drv_mode};
  wire [31:0] rd_mux =
    sel(paddr, `DMS_A_CTRL)   ? {16'h0000, ctrl_reg} :
    sel(paddr, `DMS_A_STATUS) ? status_word :
    sel(paddr, `DMS_A_OPMODE) ? {24'h000000, opmode_reg} :
    sel(paddr, `DMS_A_CFG)    ? {30'h00000000, cfg_reg} :
    sel(paddr, `DMS_A_PROG)   ? {31'h00000000, prog_run_reg} :
    sel(paddr, `DMS_A_DRIVE)  ? drive_word : 32'h00000000;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph)
        prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // software registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg          <= 16'h0000;
      cw_start_prev_reg <= 1'b0;
      opmode_reg        <= 8'h00;
      cfg_reg           <= `DMS_CFG_RST;                          // [RQ7]
    end else begin
      cw_start_prev_reg <= ctrl_reg[`DMS_CW_START];
      if (wr_ctrl)
        ctrl_reg <= pwdata[15:0];
      if (wr_opm)
        opmode_reg <= pwdata[7:0];
      if (wr_cfg)
        cfg_reg <= pwdata[1:0];
    end
  end

  // auto setup starts on a rising start bit with the mode preselected
  // the bit is edge detected, so software clears it before a retry
  wire cw_mode_specific_bit = ctrl_reg[`DMS_CW_START];
  wire as_start = cw_mode_specific_bit & ~cw_start_prev_reg &     // [RQ11]
                  (opmode_reg == `DMS_OPM_AUTOSET) & pwr_op_enabled & // [RQ10]
                  ~prog_run_reg & ~as_busy;                       // [RQ14]

  dms_autosetup u_autosetup (
    .core_clk          (core_clk),
    .rst_b             (rst_b),
    .start             (as_start),
    .enc_index_present (enc_index_present),
    .hall_present      (hall_present),
    .meas_req          (meas_req),
    .meas_step         (meas_step),
    .meas_done         (meas_done),
    .meas_err          (meas_err),
    .meas_index        (meas_index),
    .store_req         (store_req),
    .store_cat         (store_cat),
    .store_done        (store_done),
    .busy              (as_busy),
    .done              (as_done),
    .index_found       (as_index)
  );

  dms_mode_decode u_decode (
    .sw          (dip_sw),
    .sw_en       (cfg_reg[`DMS_CFG_SWEN]),                        // [RQ7]
    .mode        (dec_mode),
    .dir_ccw     (dec_dir_ccw),
    .joystick    (dec_joystick),
    .speed_max   (dec_speed_max),
    .closed_loop (dec_closed_loop)
  );

  // start-up pass: runs once after reset and after each restart request;
  // a restart arriving during start-up is still honoured (set wins)
  wire restart_pend_next = restart_file_wr | (restart_pend_reg & ~startup_reg);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      startup_reg      <= 1'b1;
      restart_pend_reg <= 1'b0;
      restart_file_del <= 1'b0;
      prog_file_create <= 1'b0;
      prog_start       <= 1'b0;
      sys_restart      <= 1'b0;
      prog_run_reg     <= 1'b0;
    end else begin
      startup_reg      <= restart_file_wr;                        // [RQ17]
      restart_pend_reg <= restart_pend_next;
      sys_restart      <= restart_file_wr;                        // [RQ17]
      restart_file_del <= startup_reg & restart_pend_reg;         // [RQ17]
      prog_file_create <= startup_reg & ~prog_file_present;       // [RQ18]
      prog_start       <= startup_reg & cfg_reg[`DMS_CFG_AUTORUN]; // [RQ16]
      if (startup_reg)
        prog_run_reg <= cfg_reg[`DMS_CFG_AUTORUN];                // [RQ16]
      else if (wr_prog)
        prog_run_reg <= pwdata[0];
    end
  end

  // drive selection is frozen between start-up passes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_mode        <= DMS_MODE_NONE;
      drv_dir_ccw     <= 1'b0;
      drv_joystick    <= 1'b0;
      drv_speed_max   <= 11'h000;
      drv_closed_loop <= 1'b0;
      cd_opmode_set   <= 1'b0;
    end else if (startup_reg) begin                               // [RQ6] [RQ22]
      drv_mode        <= dec_mode;
      drv_dir_ccw     <= dec_dir_ccw;
      drv_joystick    <= dec_joystick;
      drv_speed_max   <= dec_speed_max;
      drv_closed_loop <= dec_closed_loop;
      cd_opmode_set   <= (dec_mode == DMS_MODE_CLKDIR);           // [RQ9]
    end
  end

  // motion outputs lag their inputs by one cycle so that they stay registered
  // analog dead band: around mid-scale in joystick mode, near zero otherwise
  wire [11:0] adc_dist = !drv_joystick ? adc_value :
                         (adc_value >= `DMS_ADC_MID) ? adc_value - `DMS_ADC_MID :
                         `DMS_ADC_MID - adc_value;
  wire special = (drv_mode != DMS_MODE_NONE);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      motion_en      <= 1'b0;
      test_speed_rpm <= 11'h000;
      analog_hold    <= 1'b0;
    end else begin
      motion_en      <= special & din4_enable;                    // [RQ8]
      test_speed_rpm <= ((drv_mode == DMS_MODE_TEST) && din4_enable) ?
                        `DMS_TEST_RPM : 11'h000;                  // [RQ20]
      analog_hold    <= (drv_mode == DMS_MODE_ANALOG) &&
                        (adc_dist <= `DMS_DEAD_CNT);              // [RQ21]
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // switch checks apply while the switches are enabled; a_cd_only, a_loop_select and a_sw_disable also cover them disabled
  wire sw_use = cfg_reg[`DMS_CFG_SWEN];
  a_clkdir_select: assert property (startup_reg && sw_use && dip_sw[1:0] == 2'b00 // [RQ1] [RQ9]
    |=> drv_mode == DMS_MODE_CLKDIR && cd_opmode_set)
    else $error("clock-direction not selected");
  a_cd_only: assert property (startup_reg && !(sw_use && dip_sw[1:0] == 2'b00) |=> // [RQ9]
    !cd_opmode_set)
    else $error("operating mode set outside clock-direction");
  a_testrun_dir: assert property (startup_reg && sw_use && dip_sw[1:0] == 2'b10 |=> // [RQ2]
    drv_mode == DMS_MODE_TEST && drv_dir_ccw == $past(dip_sw[2]))
    else $error("test run mode or direction wrong");
  a_analog_sel: assert property (startup_reg && sw_use && dip_sw[0] |=> // [RQ3]
    drv_mode == DMS_MODE_ANALOG && drv_joystick == $past(dip_sw[1]))
    else $error("analog selection wrong");
  a_speed_range: assert property (startup_reg && sw_use && dip_sw[0] |=> // [RQ4]
    drv_speed_max == ($past(dip_sw[2]) ? `DMS_MAX_LO : `DMS_MAX_HI))
    else $error("analog speed range wrong");
  a_loop_select: assert property (startup_reg |=> // [RQ5]
    drv_closed_loop == ($past(sw_use) && $past(dip_sw[3])))
    else $error("loop selection wrong");
  a_mode_hold: assert property (!startup_reg |=> // [RQ6]
    $stable(drv_mode) && $stable(drv_closed_loop))
    else $error("drive mode changed while running");
  a_sw_disable: assert property (startup_reg && !sw_use |=> // [RQ7]
    drv_mode == DMS_MODE_NONE)
    else $error("switches used while disabled");
  a_enable_gate: assert property (motion_en |-> // [RQ8]
    $past(din4_enable) && $past(special))
    else $error("motion enabled without input 4");
  a_restart_seq: assert property (restart_file_wr |=> // [RQ17]
    startup_reg ##1 restart_file_del)
    else $error("restart file not deleted at start-up");
  a_sys_restart: assert property (restart_file_wr |=> sys_restart) // [RQ17]
    else $error("restart request not passed on");
  a_prog_create: assert property (startup_reg && !prog_file_present |=> // [RQ18]
    prog_file_create)
    else $error("missing program file not created");
  a_prog_autorun: assert property (prog_start |-> // [RQ16]
    $past(startup_reg) && $past(cfg_reg[`DMS_CFG_AUTORUN]))
    else $error("program started without configuration");
  a_test_speed: assert property ((drv_mode == DMS_MODE_TEST) && din4_enable |=> // [RQ20]
    test_speed_rpm == `DMS_TEST_RPM)
    else $error("test run speed not 30 rpm");
  a_joy_centre: assert property (drv_mode == DMS_MODE_ANALOG && drv_joystick && // [RQ21]
    adc_value == `DMS_ADC_MID |=> analog_hold)
    else $error("joystick centre not held");
  a_as_gate: assert property (as_start |-> // [RQ10] [RQ14]
    opmode_reg == `DMS_OPM_AUTOSET && !prog_run_reg)
    else $error("auto setup started without preselection");
endmodule
`default_nettype wire

/* testbench/dms_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dms_far_model import dms_pkg::*; (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // measurement engine
  input  wire logic       meas_req,
  input  wire dms_meas_t  meas_step,
  output logic            meas_done,
  output logic            meas_err,
  output logic            meas_index,
  // parameter store
  input  wire logic       store_req,
  input  wire logic [7:0] store_cat,
  output logic            store_done,
  // bookkeeping
  output logic [3:0]      n_meas,
  output logic [15:0]     cat_log
);
  logic [3:0] wait_reg;
  logic       m_pend, s_pend, align_reg;
  // reply delay varies per step so prompt and slow answers both occur
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {meas_done, meas_err, meas_index, store_done} <= 4'h0;
      {m_pend, s_pend, align_reg} <= 3'h0;
      wait_reg <= 4'h0;
      n_meas   <= 4'h0;
      cat_log  <= 16'h0000;
    end else begin
      meas_done  <= 1'b0;
      store_done <= 1'b0;
      meas_err   <= 1'b0;
      // index is only valid with done, so it toggles otherwise
      meas_index <= ~meas_index;
      if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (m_pend) begin
        meas_done  <= 1'b1;
        meas_index <= align_reg;
        m_pend     <= 1'b0;
      end else if (s_pend) begin
        store_done <= 1'b1;
        s_pend     <= 1'b0;
      end
      if (meas_req) begin
        m_pend    <= 1'b1;
        align_reg <= (meas_step == DMS_MEAS_ALIGN);
        wait_reg  <= {2'h0, n_meas[1:0]};
        n_meas    <= n_meas + 4'h1;
      end
      if (store_req) begin
        s_pend   <= 1'b1;
        wait_reg <= 4'h3;
        cat_log  <= {cat_log[7:0], store_cat};
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/test_drive_mode_select_autosetup.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dms_params.svh"
module test_drive_mode_select_autosetup import dms_pkg::*; ;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0]  paddr, store_cat;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  dip_sw, n_meas;
  logic [11:0] adc_value;
  logic        din4_enable, pwr_op_enabled, restart_file_wr, prog_file_present;
  logic        restart_file_del, prog_file_create, prog_start, sys_restart;
  logic        drv_dir_ccw, drv_joystick, drv_closed_loop, cd_opmode_set;
  logic        motion_en, analog_hold, enc_index_present, hall_present;
  logic        meas_req, meas_done, meas_err, meas_index, store_req, store_done;
  logic [10:0] drv_speed_max, test_speed_rpm;
  logic [15:0] cat_log;
  logic [1:0]  cfg_v;
  dms_mode_t   drv_mode;
  dms_meas_t   meas_step;
  int          bad_count, n_compared;
  wire [15:0]  drv_word = {drv_speed_max, drv_closed_loop, drv_joystick, drv_dir_ccw, drv_mode};

  dms_top dms_top_i (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dip_sw, .din4_enable, .adc_value, .pwr_op_enabled, .restart_file_wr,
    .prog_file_present, .restart_file_del, .prog_file_create, .prog_start, .sys_restart,
    .drv_mode, .drv_dir_ccw, .drv_joystick, .drv_speed_max, .drv_closed_loop, .cd_opmode_set,
    .motion_en, .test_speed_rpm, .analog_hold, .enc_index_present, .hall_present, .meas_req,
    .meas_step, .meas_done, .meas_err, .meas_index, .store_req, .store_cat, .store_done);
  dms_far_model dms_far_model_i (.core_clk, .rst_b, .meas_req, .meas_step, .meas_done,
    .meas_err, .meas_index, .store_req, .store_cat, .store_done, .n_meas, .cat_log);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] exp_drv(input logic [3:0] s);
    logic [1:0]  m;
    logic [10:0] v;
    m = s[0] ? 2'h3 : (s[1] ? 2'h2 : 2'h1);
    v = (m == 2'h3) ? (s[2] ? `DMS_MAX_LO : `DMS_MAX_HI) : (m == 2'h2 ? `DMS_TEST_RPM : 11'h0);
    return {v, s[3], (m == 2'h3) & s[1], (m == 2'h2) & s[2], m};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // restart through the storage event, then check the start-up pulses
  task automatic restart();
    @(posedge core_clk);
    restart_file_wr <= 1'b1;
    @(posedge core_clk);
    restart_file_wr <= 1'b0;
    #1 chk(sys_restart, 1'b1);
    @(posedge core_clk);
    #1 chk(restart_file_del, 1'b1);
    chk(prog_file_create, !prog_file_present);
    chk(prog_start, cfg_v[1]);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic as_run(input logic enc, input logic hall, input logic [3:0] n, input logic ok);
    logic [3:0] n0;
    int         k;
    enc_index_present <= enc;
    hall_present <= hall;
    n0 = n_meas;
    apb(1'b1, `DMS_A_CTRL, 32'h0);
    apb(1'b1, `DMS_A_CTRL, 32'h10);
    k = 0;
    if (ok) begin
      do begin
        apb(1'b0, `DMS_A_STATUS, 32'h0);
        k++;
      end while (rd[12] !== 1'b1 && k < 100);
      chk(rd[12], 1'b1);
      if (rd[12] !== 1'b1) final_report();
      chk(rd[10], enc);
      chk(cat_log, 16'h0506);
    end else repeat (40) @(posedge core_clk);
    chk(4'(n_meas - n0), n);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    final_report();
  end

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, din4_enable, restart_file_wr} = '0;
    {pwr_op_enabled, prog_file_present, enc_index_present, hall_present} = 4'hf;
    dip_sw = 4'hb;
    adc_value = `DMS_ADC_MID;
    bad_count = 0;
    n_compared = 0;
    cfg_v = 2'h1;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(drv_word, exp_drv(4'hb));
    apb(1'b0, `DMS_A_CFG, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd_err, rd[30:0]}, 32'h80000000);
    for (int s = 0; s < 16; s++) begin
      dip_sw <= 4'(s);
      prog_file_present <= s[0];
      restart();
      chk(drv_word, exp_drv(4'(s)));
      if (s[1:0] == 2'h0) chk(cd_opmode_set, 1'b1);
      if (s[0]) chk(analog_hold, s[1]);
      apb(1'b0, `DMS_A_DRIVE, 32'h0);
      chk(rd, {16'h0, exp_drv(4'(s))});
    end
    dip_sw <= 4'h0;
    repeat (4) @(posedge core_clk);
    chk(drv_word, exp_drv(4'hf));
    dip_sw <= 4'h6;
    restart();
    din4_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(motion_en, 1'b1);
    chk(test_speed_rpm, `DMS_TEST_RPM);
    din4_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(motion_en, 1'b0);
    chk(test_speed_rpm, 11'h0);
    apb(1'b1, `DMS_A_CFG, 32'h0);
    cfg_v = 2'h0;
    restart();
    chk(drv_mode, DMS_MODE_NONE);
    apb(1'b1, `DMS_A_CFG, 32'h3);
    cfg_v = 2'h3;
    restart();
    apb(1'b0, `DMS_A_PROG, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, `DMS_A_OPMODE, 32'hfe);
    as_run(1'b1, 1'b1, 4'h0, 1'b0);
    apb(1'b1, `DMS_A_PROG, 32'h0);
    as_run(1'b1, 1'b1, 4'h7, 1'b1);
    as_run(1'b0, 1'b0, 4'h4, 1'b1);
    apb(1'b1, `DMS_A_OPMODE, 32'h0);
    as_run(1'b1, 1'b1, 4'h0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
